// [qpsc_pkg.sv]
// shared constants and types for the quad pot serial command unit
package qpsc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_STORE_MS     = 2;                   // longest store time
  localparam int T_STORE_NS     = T_STORE_MS * 1000000;
  localparam int STORE_CYCLES   = T_STORE_NS / CLK_PERIOD_NS;
  localparam int T_ACCESS_NS    = 1000;                // read/load busy time
  localparam int ACCESS_CYCLES  = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

  // frame geometry
  localparam int FRAME_BITS     = 24;
  localparam int BITCNT_W       = 5;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam logic [4:0] BITCNT_MAX = 5'h1F;
  localparam int NUM_CHAN       = 4;
  localparam int NUM_SLOT       = 4;

  // command codes
  localparam logic [3:0] CMD_NOP      = 4'h0;
  localparam logic [3:0] CMD_WAKE     = 4'h1;
  localparam logic [3:0] CMD_PROGRAM  = 4'h2;
  localparam logic [3:0] CMD_SAVE     = 4'h3;
  localparam logic [3:0] CMD_WRITE    = 4'h4;
  localparam logic [3:0] CMD_UP       = 4'h7;
  localparam logic [3:0] CMD_SLEEP    = 4'h8;
  localparam logic [3:0] CMD_SWRESET  = 4'h9;
  localparam logic [3:0] CMD_RD_SLOT  = 4'hA;
  localparam logic [3:0] CMD_LOAD     = 4'hB;
  localparam logic [3:0] CMD_RD_WIPER = 4'hC;
  localparam logic [3:0] CMD_ERASE    = 4'hD;
  localparam logic [3:0] CMD_DOWN     = 4'hF;

  // wiper limits
  localparam logic [7:0] POS_TOP      = 8'hFF;
  localparam logic [7:0] POS_BOTTOM   = 8'h00;

  // one 9-bit slot word or channel setting
  typedef struct packed {
    logic       buffer_mode_bit;
    logic [7:0] pos;
  } qpsc_chan_s;

  // reset and erase values
  localparam qpsc_chan_s SLOT_INIT    = 9'h080;
  localparam qpsc_chan_s SLOT_ERASED  = 9'h1FF;

  // command frame, msb first on the wire
  typedef struct packed {
    logic [3:0] command_code;
    logic [1:0] slot_select_bits;
    logic [1:0] channel_select_bits;
    logic [6:0] dont_care;
    logic       buffer_mode_bit;
    logic [7:0] pos;
  } qpsc_frame_s;

  // power and pacing states
  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_AWAKE,
    ST_BUSY
  } qpsc_state_e;

endpackage : qpsc_pkg

// [qpsc_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module qpsc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys_in,   // system clock
  input  wire logic reset_in,     // async reset, active high
  input  wire logic pin_in,       // asynchronous pin level
  output logic      level_out     // filtered level
);

  logic s1;
  logic s2;
  logic s3;

  // first stage feeds only the second
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only when stages two and three agree
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      level_out <= RST_VAL;
    end else if (s2 == s3) begin
      level_out <= s3;
    end
  end

endmodule // qpsc_sync

// [qpsc_top.sv]
// command interpreter of the quad digital pot serial link
//
// Summary of operation
// - sleep after power-up, software reset, sleep command
// - asleep: wipers kept, only wake obeyed
// - nibble 0001 wakes, 1000 sleeps
// - nibble 1001 recalls slot zero into wipers, then sleeps
// - power commands act on all channels
// - write loads eight data bits into wiper
// - step up adds one to selected wiper
// - step down subtracts one from selected wiper
// - buffer mode changes only on slot load
// - load copies addressed slot into channel
// - slot holds wiper position plus mode bit
// - erase sets addressed nine-bit slot to all ones
// - program stores mode bit and wiper byte
// - save stores channel setting into slot
// - 1010 reads slot, 1100 reads wiper
// - read data leaves on falling clock edges
// - read data appears during next frame only
// - follow-up frame carries mode then wiper byte
// - store finishes within two milliseconds
// - frame is 24 bits, msb first
// - low address picks channel, high picks slot
// - busy low after read, program, load, save
// - sample on rising clock, act at deselect
`timescale 1ns/1ns
module qpsc_top
  import qpsc_pkg::*;
#(
  parameter int STORE_CYCLES_P  = qpsc_pkg::STORE_CYCLES,
  parameter int ACCESS_CYCLES_P = qpsc_pkg::ACCESS_CYCLES
) (
  input  wire logic  clk_sys_in,                    // system clock
  input  wire logic  reset_in,                      // async reset
  input  wire logic  spi_clk_in,                    // link clock pin
  input  wire logic  spi_cs_n_in,                   // chip select pin
  input  wire logic  spi_sdi_in,                    // serial data in
  output logic       spi_sdo_out,                   // serial data out
  output logic       spi_sdo_oe_out,                // sdo drive enable
  output logic       ready_out,                     // high when ready
  output logic       asleep_out,                    // sleep state
  output qpsc_pkg::qpsc_chan_s wiper_out [NUM_CHAN] // channel settings
);

  import qpsc_pkg::*;

  localparam int CNT_W = $clog2(STORE_CYCLES_P + 1);

  // refuse counts the timer cannot serve
  if (STORE_CYCLES_P < 1 || ACCESS_CYCLES_P < 1 ||
      ACCESS_CYCLES_P > STORE_CYCLES_P) begin : g_bad_param
    $error("qpsc_top: cycle counts out of range");
  end

  // synchronised pins
  logic sclk_f;
  logic cs_n_f;
  logic sdi_f;
  logic sclk_d;
  logic cs_n_d;

  // frame capture
  logic [FRAME_BITS-1:0] shift_in;
  logic [BITCNT_W-1:0]   bit_cnt;
  logic                  exec;
  qpsc_frame_s           frame;

  // read-back path
  qpsc_chan_s            rd_word;
  logic                  rd_pending;
  logic [FRAME_BITS-1:0] shift_out;

  // state and pacing
  qpsc_state_e           state;
  logic [CNT_W-1:0]      busy_cnt;
  logic                  awake_exec;
  logic                  soft_reset;

  // settings storage
  qpsc_chan_s            wiper_position_reg [NUM_CHAN];
  qpsc_chan_s            saved_position_slot [NUM_CHAN][NUM_SLOT];

  // edge strobes
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  // pins pass the four-flop filter before any use
  qpsc_sync #(.RST_VAL(1'b0)) u_sync_clk (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     (spi_clk_in),
    .level_out  (sclk_f)
  );

  qpsc_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     (spi_cs_n_in),
    .level_out  (cs_n_f)
  );

  qpsc_sync #(.RST_VAL(1'b0)) u_sync_sdi (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     (spi_sdi_in),
    .level_out  (sdi_f)
  );

  // delayed copies for edge detection
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_f;
      cs_n_d <= cs_n_f;
    end
  end

  // link edges, clock edges only count inside a frame
  assign sclk_rise = sclk_f & ~sclk_d & ~cs_n_f;
  assign sclk_fall = ~sclk_f & sclk_d & ~cs_n_f;
  assign cs_fall   = ~cs_n_f & cs_n_d;
  assign cs_rise   = cs_n_f & ~cs_n_d;

  // shift in msb first on rising clock edges
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      shift_in <= '0;
      bit_cnt  <= '0;
    end else if (cs_fall) begin
      bit_cnt  <= '0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[FRAME_BITS-2:0], sdi_f};
      if (bit_cnt != BITCNT_MAX) begin
        bit_cnt <= BITCNT_W'(bit_cnt + 1'b1);
      end
    end
  end

  // a frame acts at deselect, and only if exactly 24 bits came in
  assign exec  = cs_rise && (bit_cnt == FRAME_LEN);
  assign frame = qpsc_frame_s'(shift_in);

  // commands other than wake run only while awake and not busy
  assign awake_exec = exec && (state == ST_AWAKE);
  assign soft_reset = awake_exec && (frame.command_code == CMD_SWRESET);

  // power and busy state machine, one for the whole chip
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state     <= ST_SLEEP;
      busy_cnt  <= '0;
      ready_out <= 1'b1;
    end else begin
      case (state)
        ST_SLEEP: begin
          if (exec && frame.command_code == CMD_WAKE) begin
            state <= ST_AWAKE;
          end
        end
        ST_AWAKE: begin
          if (awake_exec) begin
            case (frame.command_code)
              CMD_SLEEP, CMD_SWRESET: begin
                state <= ST_SLEEP;
              end
              CMD_PROGRAM, CMD_SAVE: begin
                state     <= ST_BUSY;
                busy_cnt  <= CNT_W'(STORE_CYCLES_P);
                ready_out <= 1'b0;
              end
              CMD_RD_SLOT, CMD_RD_WIPER, CMD_LOAD: begin
                state     <= ST_BUSY;
                busy_cnt  <= CNT_W'(ACCESS_CYCLES_P);
                ready_out <= 1'b0;
              end
              default: begin
                state <= ST_AWAKE;
              end
            endcase
          end
        end
        ST_BUSY: begin
          // frames during busy are dropped; the host must wait
          if (busy_cnt <= CNT_W'(1)) begin
            state     <= ST_AWAKE;
            busy_cnt  <= '0;
            ready_out <= 1'b1;
          end else begin
            busy_cnt <= CNT_W'(busy_cnt - 1'b1);
          end
        end
        default: begin
          state <= ST_SLEEP;
        end
      endcase
    end
  end

  // sleep flag for the analog side
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      asleep_out <= 1'b1;
    end else begin
      asleep_out <= (state == ST_SLEEP) ? ~(exec &&
                     frame.command_code == CMD_WAKE) :
                    (awake_exec && (frame.command_code == CMD_SLEEP ||
                     frame.command_code == CMD_SWRESET));
    end
  end

  // per-channel wiper and slot logic
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic hit;

    // low address bits choose the channel
    assign hit = awake_exec &&
                 (frame.channel_select_bits == 2'(ch));

    // wiper register; mode moves only on a slot load
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
        wiper_position_reg[ch] <= SLOT_INIT;
      end else if (soft_reset) begin
        // power-up condition recalls slot zero on every channel
        wiper_position_reg[ch] <= saved_position_slot[ch][0];
      end else if (hit) begin
        case (frame.command_code)
          CMD_WRITE: begin
            wiper_position_reg[ch].pos <= frame.pos;
          end
          CMD_UP: begin
            if (wiper_position_reg[ch].pos != POS_TOP) begin
              wiper_position_reg[ch].pos <=
                8'(wiper_position_reg[ch].pos + 1'b1);
            end
          end
          CMD_DOWN: begin
            if (wiper_position_reg[ch].pos != POS_BOTTOM) begin
              wiper_position_reg[ch].pos <=
                8'(wiper_position_reg[ch].pos - 1'b1);
            end
          end
          CMD_LOAD: begin
            wiper_position_reg[ch] <=
              saved_position_slot[ch][frame.slot_select_bits];
          end
          default: begin
            wiper_position_reg[ch] <= wiper_position_reg[ch];
          end
        endcase
      end
    end

    // slots behave like flash: erase sets all ones, writes only clear
    for (genvar sl = 0; sl < NUM_SLOT; sl++) begin : g_slot
      logic slot_hit;

      assign slot_hit = hit &&
                        (frame.slot_select_bits == 2'(sl));

      always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
          saved_position_slot[ch][sl] <= SLOT_INIT;
        end else if (slot_hit) begin
          case (frame.command_code)
            CMD_ERASE: begin
              saved_position_slot[ch][sl] <= SLOT_ERASED;
            end
            CMD_PROGRAM: begin
              // unerased bits stay low, so skipping erase corrupts
              saved_position_slot[ch][sl] <=
                saved_position_slot[ch][sl] &
                {frame.buffer_mode_bit, frame.pos};
            end
            CMD_SAVE: begin
              saved_position_slot[ch][sl] <=
                saved_position_slot[ch][sl] &
                wiper_position_reg[ch];
            end
            default: begin
              saved_position_slot[ch][sl] <= saved_position_slot[ch][sl];
            end
          endcase
        end
      end
    end

    // settings to the analog ladder straight from the registers
    assign wiper_out[ch] = wiper_position_reg[ch];
  end

  // read commands latch the selected word for the next frame
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_word    <= '0;
      rd_pending <= 1'b0;
    end else if (awake_exec &&
                 frame.command_code == CMD_RD_SLOT) begin
      rd_word    <= saved_position_slot[frame.channel_select_bits]
                                       [frame.slot_select_bits];
      rd_pending <= 1'b1;
    end else if (awake_exec &&
                 frame.command_code == CMD_RD_WIPER) begin
      rd_word    <= wiper_position_reg[frame.channel_select_bits];
      rd_pending <= 1'b1;
    end else if (cs_fall) begin
      // offered once; the frame that starts now consumes it
      rd_pending <= 1'b0;
    end else if (soft_reset) begin
      rd_pending <= 1'b0;
    end
  end

  // serial output: load at select, shift on falling clock edges
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      shift_out      <= '0;
      spi_sdo_out    <= 1'b0;
      spi_sdo_oe_out <= 1'b0;
    end else if (cs_fall) begin
      spi_sdo_oe_out <= 1'b1;
      if (rd_pending) begin
        shift_out   <= {15'h0000, rd_word} << 1;
        spi_sdo_out <= 1'b0;
      end else begin
        shift_out   <= '0;
        spi_sdo_out <= 1'b0;
      end
    end else if (sclk_fall) begin
      spi_sdo_out <= shift_out[FRAME_BITS-1];
      shift_out   <= {shift_out[FRAME_BITS-2:0], 1'b0};
    end else if (cs_n_f) begin
      spi_sdo_oe_out <= 1'b0;
      spi_sdo_out    <= 1'b0;
    end
  end

endmodule // qpsc_top

// [qpsc_properties.sv]
// assertion checker for the quad pot serial command unit
`timescale 1ns/1ns
module qpsc_properties
  import qpsc_pkg::*;
#(
  parameter int STORE_CYCLES_P  = qpsc_pkg::STORE_CYCLES,
  parameter int ACCESS_CYCLES_P = qpsc_pkg::ACCESS_CYCLES
) (
  input wire logic                 clk_sys_in,     // system clock
  input wire logic                 reset_in,       // async reset
  input wire logic                 spi_clk_in,     // link clock pin
  input wire logic                 spi_cs_n_in,    // chip select pin
  input wire logic                 spi_sdi_in,     // serial data in
  input wire logic                 spi_sdo_out,    // serial data out
  input wire logic                 spi_sdo_oe_out, // sdo drive enable
  input wire logic                 ready_out,      // high when ready
  input wire logic                 asleep_out,     // sleep state
  input wire qpsc_pkg::qpsc_chan_s wiper_out [qpsc_pkg::NUM_CHAN] // wipers
);
  import qpsc_pkg::*;
  logic [35:0] wip_all;
  int          busy_cnt;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // packed view so one stable check covers all channels
  assign wip_all = {wiper_out[3], wiper_out[2], wiper_out[1], wiper_out[0]};

  // length of the present busy stretch
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in)
      busy_cnt <= 0;
    else if (ready_out)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end

  wiper_hold_a: assert property (
    asleep_out && $past(asleep_out) |-> $stable(wip_all))
    else $error("wiper moved while asleep");
  wiper_edge_a: assert property (
    $changed(wip_all) |-> $past(spi_cs_n_in, 3))
    else $error("wiper moved inside a frame");
  power_edge_a: assert property (
    $changed(asleep_out) |-> $past(spi_cs_n_in, 3) && spi_cs_n_in)
    else $error("power state moved inside a frame");
  busy_start_a: assert property (
    $fell(ready_out) |-> spi_cs_n_in && $past(spi_cs_n_in, 3) && !asleep_out)
    else $error("busy began without a finished awake frame");
  busy_len_a: assert property (
    $rose(ready_out) |->
      busy_cnt == STORE_CYCLES_P || busy_cnt == ACCESS_CYCLES_P)
    else $error("busy stretch of wrong length");
  store_time_a: assert property (busy_cnt <= STORE_CYCLES_P)
    else $error("busy longer than store time");
  sdo_idle_a: assert property (!spi_sdo_oe_out |-> !spi_sdo_out)
    else $error("sdo not low while released");
  oe_release_a: assert property (
    spi_cs_n_in [*6] |-> !spi_sdo_oe_out)
    else $error("sdo driven while deselected");
  oe_acquire_a: assert property (
    $fell(spi_cs_n_in) |-> ##[2:6] spi_sdo_oe_out)
    else $error("sdo not driven after select");
  sdo_fall_a: assert property (
    $changed(spi_sdo_out) && spi_sdo_oe_out && $past(spi_sdo_oe_out)
      |-> !spi_clk_in)
    else $error("sdo changed while link clock high");

  cover property ($fell(ready_out));
  cover property ($rose(asleep_out));
  cover property ($changed(spi_sdo_out) && spi_sdo_oe_out);
endmodule // qpsc_properties

bind qpsc_top qpsc_properties #(
  .STORE_CYCLES_P (STORE_CYCLES_P),
  .ACCESS_CYCLES_P(ACCESS_CYCLES_P)
) u_props (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .spi_clk_in(spi_clk_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_sdi_in(spi_sdi_in),
  .spi_sdo_out(spi_sdo_out), .spi_sdo_oe_out(spi_sdo_oe_out),
  .ready_out(ready_out), .asleep_out(asleep_out), .wiper_out(wiper_out)
);

// [qpsc_host.sv]
// host model that drives the serial link of the pot command unit
`timescale 1ns/1ns
module qpsc_host (
  input  wire logic clk_sys_in,   // system clock
  input  wire logic spi_sdo_in,   // serial data from device
  output logic      spi_clk_out,  // link clock, idle low
  output logic      spi_cs_n_out, // chip select, active low
  output logic      spi_sdi_out   // serial data to device
);
  // idle link: clock still, device deselected
  initial begin
    spi_clk_out  = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_sdi_out  = 1'b0;
  end

  // one frame at 160 ns per bit; data moves on the falling clock
  task automatic xfer(input logic [23:0] tx, input int nbits,
                      output logic [23:0] rx);
    int i;
    rx = 24'h000000;
    @(posedge clk_sys_in);
    spi_cs_n_out <= 1'b0;
    repeat (12) @(posedge clk_sys_in);
    for (i = 0; i < nbits; i++) begin
      spi_sdi_out <= tx[23 - i];
      repeat (7) @(posedge clk_sys_in);
      rx = {rx[22:0], spi_sdo_in};
      @(posedge clk_sys_in);
      spi_clk_out <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
      spi_clk_out <= 1'b0;
    end
    // the 24 samples above hold the whole word; one more would push
    // the msb out, so only the lag before deselect remains
    repeat (11) @(posedge clk_sys_in);
    spi_cs_n_out <= 1'b1;
    spi_sdi_out  <= ~spi_sdi_out; // no stale bit once deselected
  endtask
endmodule // qpsc_host

// [tb_top.sv]
// self-checking bench for the quad pot serial command unit
`timescale 1ns/1ns
module tb_top;
  import qpsc_pkg::*;
  localparam int STORE_P  = 50;
  localparam int ACCESS_P = 10;
  logic        clk_sys_in, reset_in, spi_clk, spi_cs_n, spi_sdi;
  logic        spi_sdo, sdo_oe, ready, asleep, awake;
  qpsc_chan_s  wiper [NUM_CHAN];
  logic [23:0] rx;
  int          num_errors, comparisons;
  int          cycles = 0;

  qpsc_top #(.STORE_CYCLES_P(STORE_P), .ACCESS_CYCLES_P(ACCESS_P)) u_dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .spi_clk_in(spi_clk),
    .spi_cs_n_in(spi_cs_n), .spi_sdi_in(spi_sdi), .spi_sdo_out(spi_sdo),
    .spi_sdo_oe_out(sdo_oe), .ready_out(ready), .asleep_out(asleep),
    .wiper_out(wiper));
  qpsc_host u_host (
    .clk_sys_in(clk_sys_in), .spi_sdo_in(spi_sdo), .spi_clk_out(spi_clk),
    .spi_cs_n_out(spi_cs_n), .spi_sdi_out(spi_sdi));

  // clock, reset held five cycles
  initial begin
    clk_sys_in = 1'b0;
    reset_in = 1'b1;
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
  end
  always #5 clk_sys_in = ~clk_sys_in;

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // expected settings packed as {ch3, ch2, ch1, ch0}
  task automatic chk_wip(input logic [35:0] exp);
    int c;
    for (c = 0; c < NUM_CHAN; c++)
      chk_val({15'h0000, wiper[c]}, {15'h0000, exp[9*c +: 9]});
  endtask

  // one frame, then pacing checks and wait for ready
  task automatic cmd(input logic [3:0] code, input logic [3:0] addr,
                     input logic [8:0] data, input int nbits = 24);
    logic busy;
    int   n;
    busy = awake && nbits == 24 && (code inside {CMD_PROGRAM, CMD_SAVE,
           CMD_RD_SLOT, CMD_LOAD, CMD_RD_WIPER});
    u_host.xfer({code, addr, 7'h7F, data}, nbits, rx);
    if (nbits == 24 && code == CMD_WAKE)
      awake = 1'b1;
    else if (nbits == 24 && awake && code inside {CMD_SLEEP, CMD_SWRESET})
      awake = 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk_bit(ready, !busy);
    chk_bit(asleep, !awake);
    chk_bit(sdo_oe, 1'b0);
    for (n = 0; n < 300 && ready !== 1'b1; n++) @(posedge clk_sys_in);
    chk_bit(ready, 1'b1);
    repeat (60) @(posedge clk_sys_in);
  endtask

  task automatic summarize();
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      summarize();
    end
  end

  // main sequence
  initial begin
    num_errors = 0;
    comparisons = 0;
    awake = 1'b0;
    @(negedge reset_in);
    repeat (5) @(posedge clk_sys_in);
    chk_bit(asleep, 1'b1);
    chk_wip({4{9'h080}});
    cmd(CMD_WRITE, 4'h0, 9'h055);
    cmd(CMD_RD_WIPER, 4'h0, 9'h000);
    chk_wip({4{9'h080}});
    cmd(CMD_WAKE, 4'hF, 9'h1FF);
    cmd(CMD_WRITE, 4'h0, 9'h1FF);
    cmd(CMD_WRITE, 4'h1, 9'h100);
    cmd(CMD_WRITE, 4'hE, 9'h05A);
    cmd(CMD_WRITE, 4'h3, 9'h0A5);
    chk_wip({9'h0A5, 9'h05A, 9'h000, 9'h0FF});
    cmd(CMD_UP, 4'h0, 9'h000);
    cmd(CMD_DOWN, 4'h1, 9'h000);
    cmd(CMD_UP, 4'h2, 9'h000);
    cmd(CMD_DOWN, 4'h3, 9'h000);
    chk_wip({9'h0A4, 9'h05B, 9'h000, 9'h0FF});
    cmd(CMD_ERASE, 4'h9, 9'h000);
    cmd(CMD_RD_SLOT, 4'h9, 9'h000);
    cmd(CMD_NOP, 4'h0, 9'h000);
    chk_val(rx, 24'h0001FF);
    cmd(CMD_PROGRAM, 4'h9, 9'h13C);
    cmd(CMD_LOAD, 4'h9, 9'h000);
    chk_wip({9'h0A4, 9'h05B, 9'h13C, 9'h0FF});
    cmd(CMD_ERASE, 4'hE, 9'h000);
    cmd(CMD_SAVE, 4'hE, 9'h000);
    cmd(CMD_RD_SLOT, 4'hE, 9'h000);
    cmd(CMD_RD_WIPER, 4'h1, 9'h000);
    chk_val(rx, 24'h00005B);
    cmd(CMD_NOP, 4'h0, 9'h000);
    chk_val(rx, 24'h00013C);
    cmd(CMD_NOP, 4'h0, 9'h000);
    chk_val(rx, 24'h000000);
    cmd(CMD_WRITE, 4'h0, 9'h011, 23);
    cmd(CMD_SLEEP, 4'h0, 9'h000);
    cmd(CMD_WRITE, 4'h0, 9'h022);
    cmd(CMD_UP, 4'h1, 9'h000);
    chk_wip({9'h0A4, 9'h05B, 9'h13C, 9'h0FF});
    cmd(CMD_WAKE, 4'h0, 9'h000);
    cmd(CMD_ERASE, 4'h3, 9'h000);
    cmd(CMD_PROGRAM, 4'h3, 9'h077);
    cmd(CMD_SWRESET, 4'h0, 9'h000);
    chk_wip({9'h077, 9'h080, 9'h080, 9'h080});
    summarize();
  end
endmodule // tb_top
